// >>> src/umc_consts.svh
// umc_consts: register offsets, bit positions, reset values and counts
`ifndef UMC_CONSTS_SVH
`define UMC_CONSTS_SVH
`define UMC_OFS_RX_HOLD   6'h00
`define UMC_OFS_INT_EN    6'h04
`define UMC_OFS_LINE_ST   6'h08
`define UMC_OFS_MODEM_CTL 6'h0C
`define UMC_OFS_MODEM_ST  6'h10
`define UMC_OFS_ENH_FEAT  6'h14
`define UMC_OFS_FLOW_THR  6'h18
`define UMC_OFS_TRIG_LVL  6'h1C
`define UMC_OFS_FIFO_RDY  6'h20
`define UMC_MC_DTR        0
`define UMC_MC_RTS        1
`define UMC_MC_FRDY       2
`define UMC_MC_IRQEN      3
`define UMC_MC_LOOP       4
`define UMC_MC_XANY       5
`define UMC_MC_TACC       6
`define UMC_MC_DIV4       7
`define UMC_IE_RXD        0
`define UMC_IE_THR        1
`define UMC_IE_LINE       2
`define UMC_IE_MODEM      3
`define UMC_IE_SLEEP      4
`define UMC_IE_XOFF       5
`define UMC_IE_RTSC       6
`define UMC_IE_CTSC       7
`define UMC_EF_ENH        4
`define UMC_MC_ENH_MASK   8'hE0
`define UMC_IE_ENH_MASK   8'hF0
`define UMC_MC_RST        8'h00
`define UMC_IE_RST        8'h00
`define UMC_EF_RST        8'h00
`define UMC_SYNC_RST      6'h1F
`define UMC_STRAP_CYC     3'h5
`define UMC_NSYNC         6
`endif

// >>> src/umc_pkg.sv
// umc_pkg: state record types of the block
`include "umc_consts.svh"
package umc_pkg;
  typedef struct packed {
    logic [`UMC_NSYNC-1:0] s1;
    logic [`UMC_NSYNC-1:0] s2;
    logic [`UMC_NSYNC-1:0] s3;
    logic [`UMC_NSYNC-1:0] stab;
    logic [3:0]            lvl;
    logic [3:0]            chg;
  } umc_sync_type;

  typedef struct packed {
    logic [7:0] modem_control;
    logic [7:0] interrupt_enable;
    logic [7:0] enh_feature;
    logic [7:0] flow_threshold;
    logic [7:0] trigger_level;
    logic [3:0] modem_delta;
    logic       thr_pend;
    logic       thr_arm;
    logic [7:0] rdata;
    logic       wreq;
    logic       rx_pop;
    logic       irq;
    logic       dtr_n;
    logic       rts_n;
    logic       tx_pin;
    logic       rx_core;
    logic [2:0] strap_cnt;
    logic       strap_done;
  } umc_top_type;
endpackage

// >>> src/umc_modem_if.sv
// umc_modem_if: modem line levels and changes between tracker and top
`timescale 1ns/1ps
interface umc_modem_if;
  logic       loop_en;
  logic [3:0] loop_src;
  logic [3:0] level;
  logic [3:0] change;
  logic       rx_line;
  logic       strap_lvl;
  modport ctl (output loop_en, output loop_src, input level, input change,
               input rx_line, input strap_lvl);
  modport trk (input loop_en, input loop_src, output level, output change,
               output rx_line, output strap_lvl);
endinterface

// >>> src/umc_pin_sync.sv
// umc_pin_sync: pin synchronisers and modem line change detection
`timescale 1ns/1ps
`include "umc_consts.svh"
module umc_pin_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic cts_n,
  input  wire logic dsr_n,
  input  wire logic ri_n,
  input  wire logic cd_n,
  input  wire logic rx_pin,
  input  wire logic prescale_sel_pin,
  umc_modem_if.trk  mif
);
  umc_pkg::umc_sync_type st_r;
  umc_pkg::umc_sync_type st_nxt;
  logic [`UMC_NSYNC-1:0] pins;
  logic [`UMC_NSYNC-1:0] agree;
  logic [3:0]            cur;

  assign pins = {prescale_sel_pin, rx_pin, cd_n, ri_n, dsr_n, cts_n};

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // s1 feeds only s2; a level counts once s2 and s3 agree
    agree       = ~(st_r.s2 ^ st_r.s3);
    st_nxt.stab = (agree & st_r.s3) | (~agree & st_r.stab);
    // index 0 cts, 1 dsr, 2 ri, 3 cd
    if (mif.loop_en) begin
      cur = {mif.loop_src[3], mif.loop_src[2], mif.loop_src[0], mif.loop_src[1]};
    end else begin
      cur = ~st_r.stab[3:0];
    end
    st_nxt.lvl    = cur;
    st_nxt.chg[0] = cur[0] ^ st_r.lvl[0];
    st_nxt.chg[1] = cur[1] ^ st_r.lvl[1];
    st_nxt.chg[3] = cur[3] ^ st_r.lvl[3];
    // pin rising means level falling; in loopback the control bit rising
    st_nxt.chg[2] = mif.loop_en ? (cur[2] & ~st_r.lvl[2]) : (st_r.lvl[2] & ~cur[2]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{s1: `UMC_SYNC_RST, s2: `UMC_SYNC_RST, s3: `UMC_SYNC_RST,
                stab: `UMC_SYNC_RST, lvl: 4'h0, chg: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mif.level     = st_r.lvl;
  assign mif.change    = st_r.chg;
  assign mif.rx_line   = st_r.stab[4];
  assign mif.strap_lvl = st_r.stab[5];
endmodule

// >>> src/umc_top.sv
// umc_top: modem control, modem status and interrupt enable of one channel
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "umc_consts.svh"
module umc_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  rx_head_data,
  input  wire logic [2:0]  rx_head_err,
  input  wire logic        rx_nonempty,
  input  wire logic        rx_overrun,
  input  wire logic        rx_any_err,
  input  wire logic        thr_empty,
  input  wire logic        tx_empty,
  output logic             rx_pop,
  input  wire logic [7:0]  fifo_ready_in,
  input  wire logic        rx_data_req,
  input  wire logic        line_err_req,
  input  wire logic        thr_below,
  input  wire logic        thr_written,
  input  wire logic        xoff_req,
  input  wire logic        rts_chg_req,
  input  wire logic        cts_chg_req,
  input  wire logic        auto_rts_en,
  input  wire logic        auto_rts_n,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             irq_o,
  output logic             irq_oe,
  input  wire logic        ser_tx,
  input  wire logic        ser_rx_pin,
  output logic             ser_tx_pin,
  output logic             ser_rx,
  input  wire logic        prescale_sel_pin,
  output logic             sleep_en,
  output logic             xon_any_en,
  output logic             thresh_access_en,
  output logic             prescale_div4,
  output logic             fifo_ready_en,
  output logic             loopback_en
);
  logic [1:0]           rst_pipe_r;
  logic                 rst_n;
  umc_pkg::umc_top_type st_r;
  umc_pkg::umc_top_type st_nxt;
  logic                 loop;
  logic                 req;
  logic                 commit;
  logic                 enh;
  logic                 tacc;
  logic                 arm;
  logic [7:0]           wd;
  logic [7:0]           ie_m;
  logic [7:0]           mc_m;
  logic [7:0]           line_status;
  logic [7:0]           modem_status;
  logic [7:0]           rd_val;
  logic [3:0]           clr;

  umc_modem_if mif ();

  // async assert, release through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  umc_pin_sync u_sync (
    .clock            (clock),
    .rst_n            (rst_n),
    .cts_n            (cts_n),
    .dsr_n            (dsr_n),
    .ri_n             (ri_n),
    .cd_n             (cd_n),
    .rx_pin           (ser_rx_pin),
    .prescale_sel_pin (prescale_sel_pin),
    .mif              (mif.trk)
  );

  assign loop         = st_r.modem_control[`UMC_MC_LOOP];
  assign mif.loop_en  = loop;
  assign mif.loop_src = st_r.modem_control[3:0];
  assign req          = avs_read | avs_write;
  assign commit       = req & ~st_r.wreq;
  assign enh          = st_r.enh_feature[`UMC_EF_ENH];
  assign tacc         = st_r.modem_control[`UMC_MC_TACC];
  assign wd           = avs_writedata[7:0];
  assign ie_m         = enh ? 8'hFF : ~`UMC_IE_ENH_MASK;
  assign mc_m         = enh ? 8'hFF : ~`UMC_MC_ENH_MASK;
  assign arm          = st_r.interrupt_enable[`UMC_IE_THR] & thr_below;
  // error bits come straight from the fifo head, no local copy
  assign line_status  = {rx_any_err, tx_empty, thr_empty, rx_head_err,
                         rx_overrun, rx_nonempty};
  assign modem_status = {mif.level, st_r.modem_delta};

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rx_pop = 1'b0;
    clr           = 4'h0;
    case (avs_address)
      `UMC_OFS_RX_HOLD:   rd_val = rx_head_data;
      `UMC_OFS_INT_EN:    rd_val = st_r.interrupt_enable;
      `UMC_OFS_LINE_ST:   rd_val = line_status;
      `UMC_OFS_MODEM_CTL: rd_val = st_r.modem_control;
      `UMC_OFS_MODEM_ST:  rd_val = modem_status;
      `UMC_OFS_ENH_FEAT:  rd_val = st_r.enh_feature;
      `UMC_OFS_FLOW_THR:  rd_val = st_r.flow_threshold;
      `UMC_OFS_TRIG_LVL:  rd_val = st_r.trigger_level;
      `UMC_OFS_FIFO_RDY:  rd_val = st_r.modem_control[`UMC_MC_FRDY] ? fifo_ready_in : 8'h00;
      default:            rd_val = 8'h00;
    endcase
    // bus held off until the strap has settled through the synchroniser
    if (!st_r.strap_done) begin
      st_nxt.strap_cnt = st_r.strap_cnt + 3'h1;
      if (st_r.strap_cnt == `UMC_STRAP_CYC) begin
        st_nxt.strap_done                  = 1'b1;
        st_nxt.modem_control[`UMC_MC_DIV4] = ~mif.strap_lvl;
      end
    end
    if (st_r.wreq) begin
      if (req && st_r.strap_done) begin
        st_nxt.wreq  = 1'b0;
        st_nxt.rdata = rd_val;
      end
    end else begin
      st_nxt.wreq = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        case (avs_address)
          `UMC_OFS_INT_EN: begin
            st_nxt.interrupt_enable = (st_r.interrupt_enable & ~ie_m) | (wd & ie_m);
          end
          `UMC_OFS_MODEM_CTL: begin
            st_nxt.modem_control = (st_r.modem_control & ~mc_m) | (wd & mc_m);
          end
          `UMC_OFS_ENH_FEAT: begin
            st_nxt.enh_feature = wd;
          end
          `UMC_OFS_FLOW_THR: begin
            if (enh && tacc) begin
              st_nxt.flow_threshold = wd;
            end
          end
          `UMC_OFS_TRIG_LVL: begin
            if (enh && tacc) begin
              st_nxt.trigger_level = wd;
            end
          end
          default: begin
          end
        endcase
      end
      if (avs_read && avs_address == `UMC_OFS_RX_HOLD) begin
        st_nxt.rx_pop = 1'b1;
      end
      // clear only what the read reported, so a late change survives
      if (avs_read && avs_address == `UMC_OFS_MODEM_ST) begin
        clr = st_r.rdata[3:0];
      end
    end
    st_nxt.modem_delta = (st_r.modem_delta & ~clr) | mif.change;
    st_nxt.thr_arm = arm;
    if (thr_written || !arm) begin
      st_nxt.thr_pend = 1'b0;
    end
    if (arm && !st_r.thr_arm) begin
      st_nxt.thr_pend = 1'b1;
    end
    st_nxt.irq = (st_r.interrupt_enable[`UMC_IE_RXD] & rx_data_req)
               | st_r.thr_pend
               | (st_r.interrupt_enable[`UMC_IE_LINE] & line_err_req)
               | (st_r.interrupt_enable[`UMC_IE_MODEM] & (|st_r.modem_delta))
               | (st_r.interrupt_enable[`UMC_IE_XOFF] & xoff_req)
               | (st_r.interrupt_enable[`UMC_IE_RTSC] & rts_chg_req)
               | (st_r.interrupt_enable[`UMC_IE_CTSC] & cts_chg_req);
    // dtr, rts and the transmit pin park inactive while looped back; receive takes ser_tx
    st_nxt.dtr_n = loop | ~st_r.modem_control[`UMC_MC_DTR];
    st_nxt.rts_n = loop | (auto_rts_en ? auto_rts_n : ~st_r.modem_control[`UMC_MC_RTS]);
    st_nxt.tx_pin  = loop | ser_tx;
    st_nxt.rx_core = loop ? ser_tx : mif.rx_line;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{modem_control: `UMC_MC_RST, interrupt_enable: `UMC_IE_RST,
                enh_feature: `UMC_EF_RST, wreq: 1'b1, dtr_n: 1'b1, rts_n: 1'b1,
                tx_pin: 1'b1, rx_core: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata     = {24'h00_0000, st_r.rdata};
  assign avs_waitrequest  = st_r.wreq;
  assign rx_pop           = st_r.rx_pop;
  assign dtr_n            = st_r.dtr_n;
  assign rts_n            = st_r.rts_n;
  assign irq_o            = st_r.irq;
  assign irq_oe           = st_r.modem_control[`UMC_MC_IRQEN];
  assign ser_tx_pin       = st_r.tx_pin;
  assign ser_rx           = st_r.rx_core;
  assign sleep_en         = st_r.interrupt_enable[`UMC_IE_SLEEP];
  assign xon_any_en       = st_r.modem_control[`UMC_MC_XANY];
  assign thresh_access_en = st_r.modem_control[`UMC_MC_TACC];
  assign prescale_div4    = st_r.modem_control[`UMC_MC_DIV4];
  assign fifo_ready_en    = st_r.modem_control[`UMC_MC_FRDY];
  assign loopback_en      = loop;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_lsr_err_bits: assert property (
    (st_r.wreq && avs_read && st_r.strap_done && avs_address == `UMC_OFS_LINE_ST)
    |=> (avs_readdata[4:2] == $past(rx_head_err)))
    else $error("line status error bits differ from fifo head");

  a_lsr_no_pop: assert property (
    rx_pop |-> $past(avs_read && !st_r.wreq && avs_address == `UMC_OFS_RX_HOLD))
    else $error("receive pop without a receive holding read");

  a_lsr_any_err: assert property (
    (st_r.wreq && avs_read && st_r.strap_done && avs_address == `UMC_OFS_LINE_ST)
    |=> (avs_readdata[7] == $past(rx_any_err)))
    else $error("line status bit 7 does not follow stored errors");

  a_dtr_drive: assert property (
    (!loop && st_r.modem_control[`UMC_MC_DTR]) [*2] |-> !dtr_n)
    else $error("dtr not active while control bit 0 set");

  a_rts_drive: assert property (
    (!loop && !auto_rts_en && st_r.modem_control[`UMC_MC_RTS]) [*2] |-> !rts_n)
    else $error("rts not active while control bit 1 set");

  a_irq_enable: assert property (
    (commit && avs_write && avs_byteenable[0] && avs_address == `UMC_OFS_MODEM_CTL)
    |=> (irq_oe == $past(wd[`UMC_MC_IRQEN])))
    else $error("interrupt output enable not taken from write");

  a_mc_gate: assert property (
    (commit && avs_write && avs_address == `UMC_OFS_MODEM_CTL && !enh)
    |=> $stable(st_r.modem_control[7:5]))
    else $error("protected control bits changed without enhanced enable");

  a_ie_gate: assert property (
    (commit && avs_write && avs_address == `UMC_OFS_INT_EN && !enh)
    |=> $stable(st_r.interrupt_enable[7:4]))
    else $error("protected enable bits changed without enhanced enable");

  a_delta_sticky: assert property (
    !(commit && avs_read && avs_address == `UMC_OFS_MODEM_ST)
    |=> ((st_r.modem_delta & $past(st_r.modem_delta)) == $past(st_r.modem_delta)))
    else $error("modem change bit lost without a status read");

  a_loop_levels: assert property (
    (loop && $stable(st_r.modem_control[3:0])) [*3]
    |-> (mif.level == {st_r.modem_control[3], st_r.modem_control[2],
                       st_r.modem_control[0], st_r.modem_control[1]}))
    else $error("loopback status levels differ from control bits");

  a_thr_fresh: assert property (
    ($rose(st_r.interrupt_enable[`UMC_IE_THR]) && thr_below) |=> st_r.thr_pend)
    else $error("re-enabled transmit interrupt not raised");

  a_irq_modem: assert property (
    (st_r.interrupt_enable[`UMC_IE_MODEM] && (|st_r.modem_delta)) |=> irq_o)
    else $error("modem interrupt not raised");

  a_fifo_rdy_gate: assert property (
    (st_r.wreq && avs_read && st_r.strap_done && avs_address == `UMC_OFS_FIFO_RDY
     && !st_r.modem_control[`UMC_MC_FRDY]) |=> (avs_readdata[7:0] == 8'h00))
    else $error("fifo ready register readable while disabled");

  a_ri_rise_only: assert property (
    mif.change[2] |-> (mif.level[2] == $past(loop)))
    else $error("ring change latched on the wrong edge");

  a_strap_prescale: assert property (
    $rose(st_r.strap_done) |-> (prescale_div4 == !$past(mif.strap_lvl)))
    else $error("prescale bit not taken from inverted strap");

  a_enh_write: assert property (
    (commit && avs_write && avs_byteenable[0] && avs_address == `UMC_OFS_ENH_FEAT)
    |=> (enh == $past(wd[`UMC_EF_ENH])))
    else $error("enhanced write enable not taken from write");

  a_thr_reg_gate: assert property (
    (commit && avs_write && avs_address == `UMC_OFS_FLOW_THR && !(enh && tacc))
    |=> $stable(st_r.flow_threshold))
    else $error("threshold register written while access closed");

  a_loop_serial: assert property (
    $past(loop) |-> (ser_tx_pin && (ser_rx == $past(ser_tx))))
    else $error("serial lines not looped back internally");

  c_strap_done: cover property ($rose(st_r.strap_done));
  c_loop_read: cover property (
    loop ##[1:20] (commit && avs_read && avs_address == `UMC_OFS_MODEM_ST));
  c_irq_rise: cover property ($rose(irq_o));
  c_gated_write: cover property (
    commit && avs_write && avs_address == `UMC_OFS_MODEM_CTL && !enh);
  c_pop: cover property (rx_pop);
endmodule

// >>> testbench/umc_modem_model.sv
// umc_modem_model: far-side modem driving status lines and echoing serial data
`timescale 1ns/1ps
module umc_modem_model (
  input  wire logic       clock,
  input  wire logic [3:0] want,
  input  wire logic       slow,
  input  wire logic       ser_tx_pin,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            cd_n,
  output logic            ser_rx_pin
);
  logic [3:0] held = 4'h0;
  logic [2:0] lag = 3'h0;
  // a slow modem settles its lines a few cycles late
  always @(posedge clock) begin
    lag <= (want != held && slow && lag < 3'h4) ? lag + 3'h1 : 3'h0;
    if (want != held && (!slow || lag == 3'h4)) begin
      held <= want;
    end
  end
  // lines are active low on the wire
  assign {cd_n, ri_n, dsr_n, cts_n} = ~held;
  // null-modem echo, so the receive pin never floats
  always @(posedge clock) begin
    ser_rx_pin <= ser_tx_pin;
  end
endmodule

// >>> testbench/uart_modem_ctrl_status_irq_enable_test.sv
// uart_modem_ctrl_status_irq_enable_test: self-checking bench of the modem block
`timescale 1ns/1ps
`include "umc_consts.svh"
module uart_modem_ctrl_status_irq_enable_test;
  logic        clock = 1'h0;
  logic        nrst = 1'h0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  rx_head_data = 8'h00;
  logic [2:0]  rx_head_err = 3'h0;
  logic [4:0]  st = 5'h00;
  logic [4:0]  req = 5'h00;
  logic [7:0]  fifo_ready_in = 8'h00;
  logic        thr_below = 1'h0;
  logic        thr_written = 1'h0;
  logic        auto_rts_en = 1'h0;
  logic        auto_rts_n = 1'h1;
  logic        ser_tx = 1'h1;
  logic        prescale_sel_pin = 1'h0;
  logic [3:0]  want = 4'h0;
  logic        slow = 1'h0;
  logic        rx_pop, dtr_n, rts_n, irq_o, irq_oe, ser_tx_pin, ser_rx, ser_rx_pin;
  logic        sleep_en, xon_any_en, thresh_access_en, prescale_div4;
  logic        fifo_ready_en, loopback_en, cts_n, dsr_n, ri_n, cd_n;
  int          n_errors = 0;
  int          checked = 0;
  int          pops = 0;
  int          cycles = 0;

  always #2 clock = ~clock;

  umc_top umc_top_inst (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_head_data(rx_head_data),
    .rx_head_err(rx_head_err), .rx_nonempty(st[0]), .rx_overrun(st[1]),
    .rx_any_err(st[2]), .thr_empty(st[3]), .tx_empty(st[4]), .rx_pop(rx_pop),
    .fifo_ready_in(fifo_ready_in), .rx_data_req(req[0]), .line_err_req(req[1]),
    .thr_below(thr_below), .thr_written(thr_written), .xoff_req(req[2]),
    .rts_chg_req(req[3]), .cts_chg_req(req[4]), .auto_rts_en(auto_rts_en),
    .auto_rts_n(auto_rts_n), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .irq_o(irq_o), .irq_oe(irq_oe), .ser_tx(ser_tx),
    .ser_rx_pin(ser_rx_pin), .ser_tx_pin(ser_tx_pin), .ser_rx(ser_rx),
    .prescale_sel_pin(prescale_sel_pin), .sleep_en(sleep_en),
    .xon_any_en(xon_any_en), .thresh_access_en(thresh_access_en),
    .prescale_div4(prescale_div4), .fifo_ready_en(fifo_ready_en),
    .loopback_en(loopback_en));

  umc_modem_model umc_modem_model_inst (.clock(clock), .want(want), .slow(slow),
    .ser_tx_pin(ser_tx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .cd_n(cd_n), .ser_rx_pin(ser_rx_pin));

  always @(posedge clock) begin
    if (rx_pop === 1'h1) begin
      pops++;
    end
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low; the global timeout ends a hang
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'h0, a, 8'h00, q);
    check(q, exp);
  endtask

  task automatic do_reset(input logic pin);
    nrst <= 1'h0;
    prescale_sel_pin <= pin;
    repeat (12) @(posedge clock);
    nrst <= 1'h1;
    repeat (12) @(posedge clock);
  endtask

  task automatic irq_is(input logic exp);
    repeat (4) @(posedge clock);
    check({7'h00, irq_o}, {7'h00, exp});
  endtask

  // ri change latches only on the pin going inactive
  function automatic logic [7:0] exp_msr(input logic [3:0] o, input logic [3:0] n);
    return {n, ((o ^ n) & 4'hB) | {1'h0, o[2] & ~n[2], 2'h0}};
  endfunction

  initial begin
    logic [7:0] m, e, q, k;
    logic [7:0] bitof [5];
    int i;
    bitof = '{8'h01, 8'h04, 8'h20, 8'h40, 8'h80};
    void'($urandom(59377));
    for (i = 0; i < 2; i++) begin
      do_reset(i[0]);
      rd_chk(`UMC_OFS_MODEM_CTL, {~i[0], 7'h00});
      rd_chk(`UMC_OFS_INT_EN, 8'h00);
      check({6'h00, dtr_n, rts_n}, 8'h03);
      check({6'h00, irq_oe, irq_o}, 8'h00);
    end
    $display("test reset finished");
    wr(`UMC_OFS_MODEM_CTL, 8'hFF);
    rd_chk(`UMC_OFS_MODEM_CTL, 8'h1F);
    wr(`UMC_OFS_INT_EN, 8'hFF);
    rd_chk(`UMC_OFS_INT_EN, 8'h0F);
    wr(`UMC_OFS_ENH_FEAT, 8'h10);
    repeat (8) begin
      m = 8'($urandom);
      wr(`UMC_OFS_MODEM_CTL, m);
      rd_chk(`UMC_OFS_MODEM_CTL, m);
      check({2'h0, prescale_div4, thresh_access_en, xon_any_en, loopback_en, fifo_ready_en,
             irq_oe}, {2'h0, m[7:4], m[2], m[3]});
      e = 8'($urandom);
      wr(`UMC_OFS_INT_EN, e);
      rd_chk(`UMC_OFS_INT_EN, e);
      check({7'h00, sleep_en}, {7'h00, e[4]});
    end
    avs_byteenable <= 4'h0;
    wr(`UMC_OFS_INT_EN, ~e);
    avs_byteenable <= 4'hF;
    rd_chk(`UMC_OFS_INT_EN, e);
    wr(`UMC_OFS_ENH_FEAT, 8'h00);
    k = 8'($urandom);
    wr(`UMC_OFS_MODEM_CTL, k);
    rd_chk(`UMC_OFS_MODEM_CTL, (k & 8'h1F) | (m & 8'hE0));
    wr(`UMC_OFS_INT_EN, ~e);
    rd_chk(`UMC_OFS_INT_EN, (~e & 8'h0F) | (e & 8'hF0));
    rd_chk(6'h3C, 8'h00);
    $display("test gating finished");
    wr(`UMC_OFS_ENH_FEAT, 8'h10);
    for (i = 0; i < 2; i++) begin
      k = 8'($urandom);
      wr(`UMC_OFS_MODEM_CTL, 8'h40);
      wr(i ? `UMC_OFS_TRIG_LVL : `UMC_OFS_FLOW_THR, k);
      wr(`UMC_OFS_MODEM_CTL, 8'h04);
      wr(i ? `UMC_OFS_TRIG_LVL : `UMC_OFS_FLOW_THR, ~k);
      rd_chk(i ? `UMC_OFS_TRIG_LVL : `UMC_OFS_FLOW_THR, k);
      q = 8'($urandom);
      fifo_ready_in <= q;
      rd_chk(`UMC_OFS_FIFO_RDY, q);
      wr(`UMC_OFS_MODEM_CTL, 8'h00);
      rd_chk(`UMC_OFS_FIFO_RDY, 8'h00);
    end
    $display("test threshold finished");
    repeat (8) begin
      rx_head_err <= 3'($urandom);
      rx_head_data <= 8'($urandom);
      st <= 5'($urandom);
      @(posedge clock);
      i = pops;
      rd_chk(`UMC_OFS_LINE_ST, {st[2], st[4], st[3], rx_head_err, st[1:0]});
      rd_chk(`UMC_OFS_LINE_ST, {st[2], st[4], st[3], rx_head_err, st[1:0]});
      rd_chk(`UMC_OFS_RX_HOLD, rx_head_data);
      repeat (2) @(posedge clock);
      check(8'(pops - i), 8'h01);
    end
    $display("test line status finished");
    wr(`UMC_OFS_INT_EN, 8'h08);
    repeat (10) @(posedge clock);
    bus(1'h0, `UMC_OFS_MODEM_ST, 8'h00, q);
    repeat (10) begin
      m[3:0] = 4'($urandom);
      e[3:0] = want;
      want <= m[3:0];
      slow <= 1'($urandom);
      repeat (20) @(posedge clock);
      k = exp_msr(e[3:0], m[3:0]);
      check({7'h00, irq_o}, {7'h00, |k[3:0]});
      rd_chk(`UMC_OFS_MODEM_ST, k);
      rd_chk(`UMC_OFS_MODEM_ST, {m[3:0], 4'h0});
    end
    $display("test modem status finished");
    wr(`UMC_OFS_INT_EN, 8'h00);
    repeat (6) begin
      m = 8'($urandom) & 8'h0F;
      auto_rts_en <= 1'($urandom);
      auto_rts_n <= 1'($urandom);
      ser_tx <= 1'($urandom);
      wr(`UMC_OFS_MODEM_CTL, m);
      repeat (8) @(posedge clock);
      check({4'h0, dtr_n, rts_n, irq_oe, ser_rx},
            {4'h0, ~m[0], auto_rts_en ? auto_rts_n : ~m[1], m[3], ser_tx});
      wr(`UMC_OFS_MODEM_CTL, m | 8'h10);
      ser_tx <= ~ser_tx;
      repeat (8) @(posedge clock);
      bus(1'h0, `UMC_OFS_MODEM_ST, 8'h00, q);
      check({4'h0, q[7:4]}, {4'h0, m[3], m[2], m[0], m[1]});
      check({4'h0, dtr_n, rts_n, ser_tx_pin, ser_rx}, {7'h07, ser_tx});
    end
    $display("test loopback finished");
    wr(`UMC_OFS_MODEM_CTL, 8'h08);
    repeat (10) @(posedge clock);
    bus(1'h0, `UMC_OFS_MODEM_ST, 8'h00, q);
    for (i = 0; i < 10; i++) begin
      e = (i < 5) ? bitof[i % 5] : (~bitof[i % 5] & 8'hE5);
      wr(`UMC_OFS_INT_EN, e);
      req <= 5'h01 << (i % 5);
      irq_is(i < 5);
      req <= 5'h00;
    end
    thr_below <= 1'h1;
    wr(`UMC_OFS_INT_EN, 8'h02);
    irq_is(1'h1);
    thr_written <= 1'h1;
    @(posedge clock);
    thr_written <= 1'h0;
    irq_is(1'h0);
    wr(`UMC_OFS_INT_EN, 8'h00);
    wr(`UMC_OFS_INT_EN, 8'h02);
    irq_is(1'h1);
    $display("test interrupts finished");
    results();
  end
endmodule
